/* hw/bscan_pkg.sv */
// Purpose: Shared constants and types for the boundary-scan instruction unit.
// Assumes: An 8-bit instruction register and a small boundary chain.
// Notes: Instruction codes other than the identification code are local choices.
package bscan_pkg;
   // Width of the instruction register.
   localparam int IR_W = 8;
   // Length of the boundary chain; the top three cells are output enables.
   localparam int CHAIN_W = 16;
   // Number of functional pins covered by the chain.
   localparam int PIN_W = 13;
   // Instruction codes.
   localparam logic [7:0] INS_EXTEST = 8'h00;
   localparam logic [7:0] INS_SAMPLE = 8'h01;
   localparam logic [7:0] INS_IDCODE = 8'h03;
   localparam logic [7:0] INS_BYPASS = 8'hFF;
   // Value loaded into the instruction shifter in Capture-IR.
   localparam logic [7:0] IR_CAPTURE = 8'h01;
   // Fields of the identification word; the values are arbitrary.
   localparam logic [3:0] ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PRODUCT = 16'h1234;
   localparam logic [10:0] ID_MAKER = 11'h055;
   // Positions of the enable cells at the top of the chain.
   localparam int EN_LSB = 13;
   // Reset values.
   localparam logic [15:0] CHAIN_RESET = 16'h0000;
   // Selected data register.
   typedef enum logic [1:0] {SEL_BYPASS, SEL_CHAIN, SEL_ID} dr_sel_e;
   // Strobes decoded from the TAP state, each high while the TAP rests in that state.
   typedef struct packed {
      logic tlr;
      logic cap_dr;
      logic sh_dr;
      logic upd_dr;
      logic cap_ir;
      logic sh_ir;
      logic upd_ir;
   } tap_strobe_s;
endpackage

/* hw/bscan_unit.sv */
// Purpose: Test port instruction unit driving the chain, bypass and ID paths.
// Assumes: Test clock is slow compared to clk_sys_i and is sampled here.
// Notes: The pin-side mux sits here so the chain can take the pins.
// How it works
// - EXTEST puts boundary chain on data path.
// - EXTEST drives updated outputs, captures input pins.
// - SAMPLE/PRELOAD puts chain on data path.
// - SAMPLE captures all pad levels at Capture-DR.
// - Shifting under SAMPLE leaves system pins alone.
// - BYPASS selects the one-bit bypass stage.
// - BYPASS leaves system logic driving pins.
// - IDCODE selects the identification register.
// - ID is 32 bits, bit 0 one, LSB first.
// - Reset selects IDCODE, clears top chain bits.
// - Capture-IR loads 00000001 into instruction shifter.
// - Sample inputs on rise, change output on fall.
module bscan_unit (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic test_clock_i,
   input wire logic test_mode_select_i,
   input wire logic test_data_in_i,
   input wire logic test_reset_n_i,
   output logic test_data_out_o,
   output logic test_data_out_oe_o,
   input wire logic [bscan_pkg::PIN_W-1:0] sys_out_i,
   input wire logic [2:0] sys_oe_i,
   input wire logic [bscan_pkg::PIN_W-1:0] pad_in_i,
   output logic [bscan_pkg::PIN_W-1:0] pad_out_o,
   output logic [2:0] pad_oe_o
);
   // TAP states.
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } tap_e;

   // Synchronised test pins and test clock edges.
   logic tck_rise, tck_fall, tms_s, tdi_s, trst_n_s;
   // Pin levels after their own two-flop synchronisers.
   logic [bscan_pkg::PIN_W-1:0] pad_s;

   // Decode of an instruction to its data register.
   function automatic bscan_pkg::dr_sel_e decode_ins(input logic [7:0] ins);
      bscan_pkg::dr_sel_e r;
      r = bscan_pkg::SEL_BYPASS;
      if (ins == bscan_pkg::INS_EXTEST || ins == bscan_pkg::INS_SAMPLE) begin
         r = bscan_pkg::SEL_CHAIN;
      end else if (ins == bscan_pkg::INS_IDCODE) begin
         r = bscan_pkg::SEL_ID;
      end
      return r;
   endfunction

   // Test clock edge detector.
   edge_sync u_tck (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .async_i(test_clock_i),
      .level_o(), .rise_o(tck_rise), .fall_o(tck_fall));
   // Mode select synchroniser.
   edge_sync u_tms (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .async_i(test_mode_select_i),
      .level_o(tms_s), .rise_o(), .fall_o());
   // Data input synchroniser.
   edge_sync u_tdi (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .async_i(test_data_in_i),
      .level_o(tdi_s), .rise_o(), .fall_o());
   // Test reset synchroniser; resets to the asserted level.
   edge_sync u_trst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .async_i(test_reset_n_i),
      .level_o(trst_n_s), .rise_o(), .fall_o());
   // Each pin level is synchronised before the chain may capture it.
   for (genvar g = 0; g < bscan_pkg::PIN_W; g++) begin : g_pad_sync
      edge_sync u_pad (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .async_i(pad_in_i[g]),
         .level_o(pad_s[g]), .rise_o(), .fall_o());
   end

   // Registers.
   tap_e state_q, state_d;
   logic [7:0] ir_sh_q; // Instruction shifter.
   logic [7:0] ir_q; // Current instruction.
   logic [bscan_pkg::CHAIN_W-1:0] ch_sh_q; // Chain shift stages.
   logic [bscan_pkg::CHAIN_W-1:0] ch_up_q; // Chain update latches.
   logic [31:0] id_sh_q; // Identification shifter.
   logic byp_q; // Bypass stage.
   logic tdo_q, tdo_oe_q; // Output pin registers.

   // Decoded selections and strobes.
   wire bscan_pkg::dr_sel_e sel = decode_ins(ir_q);
   wire extest = (ir_q == bscan_pkg::INS_EXTEST);
   // The identification word is fixed; bit 0 is always one.
   wire [31:0] id_word = {bscan_pkg::ID_VERSION, bscan_pkg::ID_PRODUCT,
      bscan_pkg::ID_MAKER, 1'b1};
   // SAMPLE sees the system enables and the synchronised pin levels.
   wire [bscan_pkg::CHAIN_W-1:0] pads = {sys_oe_i, pad_s};
   // EXTEST keeps the enable cells and takes the synchronised pin levels.
   wire [bscan_pkg::CHAIN_W-1:0] extest_cap = {ch_up_q[15:13], pad_s};
   // Each strobe stands for as long as the TAP rests in its state.
   bscan_pkg::tap_strobe_s stb;
   assign stb.tlr = (state_q == ST_TLR);
   assign stb.cap_dr = (state_q == ST_CAP_DR);
   assign stb.sh_dr = (state_q == ST_SH_DR);
   assign stb.upd_dr = (state_q == ST_UPD_DR);
   assign stb.cap_ir = (state_q == ST_CAP_IR);
   assign stb.sh_ir = (state_q == ST_SH_IR);
   assign stb.upd_ir = (state_q == ST_UPD_IR);

   // Serial output selected by state and instruction.
   logic tdo_mux;
   always_comb begin
      tdo_mux = byp_q;
      if (stb.sh_ir) begin
         tdo_mux = ir_sh_q[0];
      end else if (sel == bscan_pkg::SEL_CHAIN) begin
         tdo_mux = ch_sh_q[0];
      end else if (sel == bscan_pkg::SEL_ID) begin
         tdo_mux = id_sh_q[0];
      end
   end

   // Standard sixteen-state TAP transitions.
   // The mode select level picks the next state at each test clock rise.
   always_comb begin
      case (state_q)
         ST_TLR: state_d = tms_s ? ST_TLR : ST_RTI;
         ST_RTI: state_d = tms_s ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR: state_d = tms_s ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_d = tms_s ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR: state_d = tms_s ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_RTI;
         default: state_d = ST_TLR;
      endcase
   end

   // State advances on the test clock rising edge; test reset forces TLR.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !trst_n_s) begin
         state_q <= ST_TLR;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // Instruction shifter and current instruction.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !trst_n_s) begin
         ir_sh_q <= bscan_pkg::IR_CAPTURE;
         ir_q <= bscan_pkg::INS_IDCODE;
      end else if (tck_rise) begin
         if (stb.tlr) begin
            ir_q <= bscan_pkg::INS_IDCODE;
         end else if (stb.cap_ir) begin
            ir_sh_q <= bscan_pkg::IR_CAPTURE;
         end else if (stb.sh_ir) begin
            ir_sh_q <= {tdi_s, ir_sh_q[7:1]};
         end else if (stb.upd_ir) begin
            // A shifted instruction takes effect only here, never in mid-shift.
            ir_q <= ir_sh_q;
         end
      end
   end

   // Boundary chain capture, shift and update.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !trst_n_s) begin
         ch_sh_q <= bscan_pkg::CHAIN_RESET;
         ch_up_q <= bscan_pkg::CHAIN_RESET;
      end else if (tck_rise) begin
         if (stb.tlr) begin
            // Leaving by the mode pin clears only the enable cells.
            ch_up_q[15:13] <= 3'h0;
         end else if (sel == bscan_pkg::SEL_CHAIN && stb.cap_dr) begin
            ch_sh_q <= extest ? extest_cap : pads;
         end else if (sel == bscan_pkg::SEL_CHAIN && stb.sh_dr) begin
            ch_sh_q <= {tdi_s, ch_sh_q[15:1]};
         end else if (sel == bscan_pkg::SEL_CHAIN && stb.upd_dr) begin
            ch_up_q <= ch_sh_q;
         end
      end
   end

   // Identification and bypass shifters.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         id_sh_q <= 32'h0000_0000;
         byp_q <= 1'b0;
      end else if (tck_rise) begin
         if (stb.cap_dr) begin
            id_sh_q <= id_word;
            // Bypass captures zero so that a stuck path shows up.
            byp_q <= 1'b0;
         end else if (stb.sh_dr) begin
            id_sh_q <= {tdi_s, id_sh_q[31:1]};
            byp_q <= tdi_s;
         end
      end
   end

   // Output pin changes on the test clock falling edge.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= tdo_mux;
         // The enable is high only while a register shifts.
         tdo_oe_q <= stb.sh_dr | stb.sh_ir;
      end
   end

   // The serial pins come straight from their registers.
   assign test_data_out_o = tdo_q;
   assign test_data_out_oe_o = tdo_oe_q;
   // Pins take the chain only under EXTEST, system logic otherwise.
   assign pad_out_o = extest ? ch_up_q[12:0] : sys_out_i;
   assign pad_oe_o = extest ? ch_up_q[15:13] : sys_oe_i;
endmodule // bscan_unit

/* hw/edge_sync.sv */
// Purpose: Two-flop synchroniser with rising and falling edge pulses.
// Assumes: Input comes from another clock domain.
// Notes: The first flop feeds only the second flop.
module edge_sync (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   // Metastability stage, second stage and history flop.
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Sampling chain.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge pulses come from the synchronised stages only.
   assign level_o = sync_q;
   assign rise_o = sync_q & ~prev_q;
   assign fall_o = ~sync_q & prev_q;
endmodule // edge_sync

/* testbench/boundary_scan_instruction_unit_tb.sv */
// Purpose: Self-checking bench for the test port instruction unit.
// Assumes: The tester model drives all test pins.
// Notes: Pin patterns are fixed so every expectation is known.
module boundary_scan_instruction_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic tck, tms, tdi, trst_n, tdo, tdo_oe;
   logic [bscan_pkg::PIN_W-1:0] sys_out = 13'h1C3A;
   logic [2:0] sys_oe = 3'h2;
   logic [bscan_pkg::PIN_W-1:0] pad_in = 13'h0F31;
   logic [bscan_pkg::PIN_W-1:0] pad_out;
   logic [2:0] pad_oe;
   logic [31:0] got;
   int fails = 0;
   int tests_run = 0;
   int oe_cycles = 0; // Clock edges seen with the serial enable high.
   always #25 clk_sys_i = ~clk_sys_i;
   // Counts the time the serial output is enabled.
   always @(posedge clk_sys_i) begin
      if (tdo_oe === 1'b1) begin
         oe_cycles <= oe_cycles + 1;
      end
   end
   bscan_unit u_bscan_unit (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .test_clock_i(tck),
      .test_mode_select_i(tms), .test_data_in_i(tdi), .test_reset_n_i(trst_n),
      .test_data_out_o(tdo), .test_data_out_oe_o(tdo_oe), .sys_out_i(sys_out),
      .sys_oe_i(sys_oe), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe));
   jtag_tester u_jtag_tester (.clk_sys_i(clk_sys_i), .test_data_out_i(tdo),
      .test_clock_o(tck), .test_mode_select_o(tms), .test_data_in_o(tdi),
      .test_reset_n_o(trst_n));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
      tests_run++;
      if (act !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, act);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic t_idcode();
      logic [31:0] exp_id;
      int oe_base;
      exp_id = {bscan_pkg::ID_VERSION, bscan_pkg::ID_PRODUCT, bscan_pkg::ID_MAKER, 1'b1};
      oe_base = oe_cycles;
      u_jtag_tester.scan(1'b0, 32, 32'h00000000, got);
      check("idcode", exp_id, got);
      check("idcode enable", 32'h00000100, 32'(oe_cycles - oe_base));
      check("enable idle", 32'h00000000, 32'(tdo_oe));
   endtask
   task automatic t_sample();
      u_jtag_tester.scan(1'b1, 8, 32'(bscan_pkg::INS_SAMPLE), got);
      check("ir capture", 32'(bscan_pkg::IR_CAPTURE), got);
      u_jtag_tester.scan(1'b0, 16, 32'h0000B1E5, got);
      check("sample", 32'({sys_oe, pad_in}), got);
      check("sample pins", 32'({sys_oe, sys_out}), 32'({pad_oe, pad_out}));
   endtask
   task automatic t_extest();
      u_jtag_tester.scan(1'b1, 8, 32'(bscan_pkg::INS_EXTEST), got);
      check("preload drive", 32'h0000B1E5, 32'({pad_oe, pad_out}));
      u_jtag_tester.scan(1'b0, 16, 32'h00006E1A, got);
      check("extest capture", 32'({3'h5, pad_in}), got);
      check("extest drive", 32'h00006E1A, 32'({pad_oe, pad_out}));
      pad_in <= 13'h10C6;
      u_jtag_tester.scan(1'b0, 16, 32'h0000A5C3, got);
      check("next capture", 32'({3'h3, 13'h10C6}), got);
      check("next drive", 32'h0000A5C3, 32'({pad_oe, pad_out}));
      u_jtag_tester.to_idle();
      u_jtag_tester.scan(1'b1, 8, 32'(bscan_pkg::INS_EXTEST), got);
      check("mode reset enables", 32'h000005C3, 32'({pad_oe, pad_out}));
   endtask
   task automatic t_bypass();
      logic [7:0] codes [3];
      codes = '{bscan_pkg::INS_BYPASS, 8'h5A, 8'h02};
      foreach (codes[k]) begin
         u_jtag_tester.scan(1'b1, 8, 32'(codes[k]), got);
         u_jtag_tester.scan(1'b0, 8, 32'h000000C9, got);
         check("bypass", 32'h00000092, got);
         check("bypass pins", 32'({sys_oe, sys_out}), 32'({pad_oe, pad_out}));
         u_jtag_tester.scan_pause(8, 32'h00000036, got);
         check("bypass paused", 32'h0000006C, got);
      end
   endtask
   task automatic t_test_reset();
      u_jtag_tester.scan(1'b1, 8, 32'(bscan_pkg::INS_EXTEST), got);
      u_jtag_tester.hold_reset();
      check("reset pins", 32'({sys_oe, sys_out}), 32'({pad_oe, pad_out}));
      t_idcode();
      u_jtag_tester.scan(1'b1, 8, 32'(bscan_pkg::INS_EXTEST), got);
      check("reset enables", 32'h00000000, 32'(pad_oe));
   endtask
   // Main sequence: reset, then each scenario in interconnect test order.
   initial begin
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      u_jtag_tester.to_idle();
      t_idcode();
      t_sample();
      t_extest();
      t_bypass();
      t_test_reset();
      test_done();
   end
   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      fails++;
      test_done();
   end
endmodule // boundary_scan_instruction_unit_tb

/* testbench/bscan_unit_sva.sv */
// Purpose: Pin timing checks for the test port unit.
// Assumes: The test clock is slow against clk_sys_i.
// Notes: Counters give the age of the last test clock edges.
module bscan_unit_sva (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic test_clock_i,
   input wire logic test_reset_n_i,
   input wire logic test_data_out_o,
   input wire logic test_data_out_oe_o,
   input wire logic [bscan_pkg::PIN_W-1:0] sys_out_i,
   input wire logic [2:0] sys_oe_i,
   input wire logic [bscan_pkg::PIN_W-1:0] pad_out_o,
   input wire logic [2:0] pad_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tck_q; // Test clock as last sampled.
   logic [7:0] fall_q; // Cycles since a falling edge.
   logic [7:0] rise_q; // Cycles since a rising edge.
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // The ages saturate so that a long idle never wraps.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tck_q <= 1'b0;
         fall_q <= 8'h00;
         rise_q <= 8'h00;
      end else begin
         tck_q <= test_clock_i;
         fall_q <= (tck_q && !test_clock_i) ? 8'h00 : fall_q + {7'h00, fall_q != 8'hFF};
         rise_q <= (!tck_q && test_clock_i) ? 8'h00 : rise_q + {7'h00, rise_q != 8'hFF};
      end
   end
   a_tdo_after_fall: assert property ($changed(test_data_out_o) |-> fall_q <= 8'h06)
      else $error("Serial output moved away from a falling edge.");
   a_oe_after_fall: assert property ($changed(test_data_out_oe_o) |-> fall_q <= 8'h06)
      else $error("Serial enable moved away from a falling edge.");
   a_tdo_holds_high: assert property ($rose(test_clock_i) |=> $stable(test_data_out_o) [*3])
      else $error("Serial output moved while the test clock was high.");
   a_oe_holds_high: assert property ($rose(test_clock_i) |=> $stable(test_data_out_oe_o) [*3])
      else $error("Serial enable moved while the test clock was high.");
   a_pad_after_rise: assert property (
      $changed(pad_out_o) && $stable(sys_out_i) && test_reset_n_i |-> rise_q <= 8'h06)
      else $error("Pins moved away from a rising edge.");
   a_en_after_rise: assert property (
      $changed(pad_oe_o) && $stable(sys_oe_i) && test_reset_n_i |-> rise_q <= 8'h06)
      else $error("Pin enables moved away from a rising edge.");
   a_reset_pins: assert property (!test_reset_n_i [*8] |-> pad_out_o == sys_out_i)
      else $error("Pins not given back to system logic in test reset.");
   a_reset_ens: assert property (!test_reset_n_i [*8] |-> pad_oe_o == sys_oe_i)
      else $error("Pin enables not given back to system logic in test reset.");
endmodule // bscan_unit_sva

bind bscan_unit bscan_unit_sva u_bscan_unit_sva (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
   .test_clock_i(test_clock_i), .test_reset_n_i(test_reset_n_i),
   .test_data_out_o(test_data_out_o), .test_data_out_oe_o(test_data_out_oe_o),
   .sys_out_i(sys_out_i), .sys_oe_i(sys_oe_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));

/* testbench/jtag_tester.sv */
// Purpose: Behavioural boundary-scan tester for the test port.
// Assumes: Tasks are entered just after a rising edge of clk_sys_i.
// Notes: The test clock idles low between frames; 8 cycles make 400 ns.
module jtag_tester (
   input wire logic clk_sys_i,
   input wire logic test_data_out_i,
   output logic test_clock_o,
   output logic test_mode_select_o,
   output logic test_data_in_o,
   output logic test_reset_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle levels before the first frame.
   initial begin
      test_clock_o = 1'b0;
      test_mode_select_o = 1'b1;
      test_data_in_o = 1'b0;
      test_reset_n_o = 1'b1;
   end
   // Inputs change with the fall, output is read late in the high phase.
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      test_clock_o <= 1'b0;
      test_mode_select_o <= tms;
      test_data_in_o <= tdi;
      repeat (4) @(posedge clk_sys_i);
      test_clock_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      tdo = test_data_out_i;
      @(posedge clk_sys_i);
   endtask
   // Five ones reach Test-Logic-Reset, a zero moves on to idle.
   task automatic to_idle();
      logic b;
      repeat (5) tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b0, b);
   endtask
   // Scans len bits LSB first through a data or instruction path and updates.
   task automatic scan(input logic ir, input int len, input logic [31:0] din,
                       output logic [31:0] dout);
      logic b;
      dout = 32'h00000000;
      tick(1'b1, 1'b0, b);
      if (ir) tick(1'b1, 1'b1, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b1, b);
      for (int i = 0; i < len; i++) begin
         tick(i == len - 1, din[i], b);
         dout[i] = b;
      end
      tick(1'b1, ~din[len-1], b);
      tick(1'b0, din[len-1], b);
      test_clock_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask
   // Data scan that rests in Pause-DR after half the bits, then resumes.
   task automatic scan_pause(input int len, input logic [31:0] din, output logic [31:0] dout);
      logic b;
      dout = 32'h00000000;
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (int i = 0; i < len; i++) begin
         tick(i == len / 2 - 1 || i == len - 1, din[i], b);
         dout[i] = b;
         if (i == len / 2 - 1) begin
            tick(1'b0, 1'b0, b);
            tick(1'b0, 1'b0, b);
            tick(1'b1, 1'b0, b);
            tick(1'b0, 1'b0, b);
         end
      end
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      test_clock_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask
   // Holds the test reset low, then leaves reset for idle.
   task automatic hold_reset();
      logic b;
      test_reset_n_o <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      test_reset_n_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      tick(1'b0, 1'b0, b);
   endtask
endmodule // jtag_tester
